// >>> hw/ardm_pkg.sv
/*
 Shared constants and carrier types for the conversion result modification block.
 Assumes a converter core that presents one 12-bit result with a target register index.
*/
package ardm_pkg;
  localparam int unsigned NUM_REGS   = 16;
  localparam int unsigned IDX_W      = 4;
  localparam int unsigned CONV_W     = 12;
  localparam int unsigned RES_W      = 16;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;

  // Register map, one word per register; control y at CTRL_BASE + 4*y, result y at RES_BASE + 4*y
  localparam logic [ADDR_W-1:0] CTRL_BASE    = 8'h00;
  localparam logic [ADDR_W-1:0] RES_BASE     = 8'h40;
  localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h80;
  localparam logic [ADDR_W-1:0] MASK_OFS     = 8'h84;
  localparam logic [ADDR_W-1:0] FLT_INIT_OFS = 8'h88;

  // Control register fields
  localparam int unsigned RED_LSB  = 0;
  localparam int unsigned MODE_LSB = 4;
  // Result register read-back fields
  localparam int unsigned CNT_LSB   = 16;
  localparam int unsigned VALID_BIT = 20;

  localparam logic [1:0] MODE_REDUCE = 2'h0;
  localparam logic [1:0] MODE_FILTER = 2'h1;
  localparam logic [3:0] RED_NONE    = 4'h0;
  localparam logic [3:0] IIR_A2B2    = 4'he;
  localparam logic [3:0] IIR_A3B4    = 4'hf;
  localparam logic [5:0] CTRL_RESET  = 6'h00;
  localparam int unsigned FILT_REG_LO = 7;
  localparam int unsigned FILT_REG_HI = 15;

  typedef struct packed {
    logic [1:0] modification_mode_field;
    logic [3:0] reduction_control_field;
  } ardm_ctrl_t;

  typedef struct packed {
    logic [IDX_W-1:0]  idx;
    logic [CONV_W-1:0] data;
  } ardm_conv_t;

  typedef struct packed {
    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] c;
  } ardm_coef_t;
endpackage

// >>> hw/ardm_filter.sv
/*
 Filter arithmetic for one filtering-capable result register.
 Assumes the caller holds the history and applies the result on the same cycle.
*/
`timescale 1ns/100ps
module ardm_filter
  import ardm_pkg::*;
(
  input  wire logic [3:0]        code,
  input  wire logic [CONV_W-1:0] x0,
  input  wire logic [CONV_W-1:0] x1,
  input  wire logic [CONV_W-1:0] x2,
  input  wire logic [RES_W-1:0]  y_prev,
  output logic      [RES_W-1:0]  y
);
  ardm_coef_t cf;
  logic [RES_W+2:0] acc;

  always_comb begin
    unique case (code)
      4'h0: cf = '{a: 2'd2, b: 2'd1, c: 2'd0};
      4'h1: cf = '{a: 2'd1, b: 2'd2, c: 2'd0};
      4'h2: cf = '{a: 2'd2, b: 2'd0, c: 2'd1};
      4'h3: cf = '{a: 2'd1, b: 2'd1, c: 2'd1};
      4'h4: cf = '{a: 2'd1, b: 2'd0, c: 2'd2};
      4'h5: cf = '{a: 2'd3, b: 2'd1, c: 2'd0};
      4'h6: cf = '{a: 2'd2, b: 2'd2, c: 2'd0};
      4'h7: cf = '{a: 2'd1, b: 2'd3, c: 2'd0};
      4'h8: cf = '{a: 2'd3, b: 2'd0, c: 2'd1};
      4'h9: cf = '{a: 2'd2, b: 2'd1, c: 2'd1};
      4'ha: cf = '{a: 2'd1, b: 2'd2, c: 2'd1};
      4'hb: cf = '{a: 2'd2, b: 2'd0, c: 2'd2};
      4'hc: cf = '{a: 2'd1, b: 2'd1, c: 2'd2};
      4'hd: cf = '{a: 2'd1, b: 2'd0, c: 2'd3};
      4'he: cf = '{a: 2'd2, b: 2'd2, c: 2'd0};
      4'hf: cf = '{a: 2'd3, b: 2'd0, c: 2'd0};
    endcase
  end

  always_comb begin
    if (code == IIR_A2B2) begin
      // y = (2*y_prev)/4 + 2*x: steady state 4*x
      acc = 19'({y_prev, 1'b0} >> 2) + 19'({x0, 1'b0});
    end else if (code == IIR_A3B4) begin
      // y = (3*y_prev)/4 + x: steady state 4*x
      acc = 19'((19'(y_prev) * 19'd3) >> 2) + 19'(x0);
    end else begin
      // Gain equals the coefficient sum, never scaled back
      acc = 19'(cf.a) * 19'(x0) + 19'(cf.b) * 19'(x1) + 19'(cf.c) * 19'(x2);
    end
  end

  assign y = acc[RES_W-1:0];
endmodule

// >>> hw/ardm_top.sv
/*
 Conversion result modification stage: per-register accumulation, FIR/IIR filtering on registers 7 and 15 only,
 with a plain register port and one level interrupt.
 Assumes conversion results arrive on ref_clk as one-cycle strobes from the converter core.
*/
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
module ardm_top
  import ardm_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              conv_valid,
  input  wire ardm_conv_t        conv,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  output logic                   irq
);
  ardm_ctrl_t              result_control_register [NUM_REGS];
  logic [RES_W-1:0]        conversion_result_register [NUM_REGS];
  logic [3:0]              remaining_accumulation_counter [NUM_REGS];
  logic [NUM_REGS-1:0]     result_valid_flag;
  logic [NUM_REGS-1:0]     status;
  logic [NUM_REGS-1:0]     mask;
  logic [CONV_W-1:0]       hist1 [2];
  logic [CONV_W-1:0]       hist2 [2];
  logic [RES_W-1:0]        filt_y [2];
  logic [NUM_REGS-1:0]     event_set;
  logic [NUM_REGS-1:0]     rd_clear;
  logic [1:0]              hist_init;

  wire logic [3:0] wr_idx = addr[5:2];
  wire logic       wr_ctrl = wr && addr[7:6] == CTRL_BASE[7:6];
  wire logic       rd_res  = rd && addr[7:6] == RES_BASE[7:6];

  // Only registers 7 and 15 carry filter hardware; elsewhere mode 01 reduces
  function automatic logic filt_slot(input logic [3:0] i);
    filt_slot = (i == 4'(FILT_REG_LO)) || (i == 4'(FILT_REG_HI));
  endfunction

  genvar f;
  generate
    for (f = 0; f < 2; f++) begin : g_filt
      localparam int unsigned RI = f ? FILT_REG_HI : FILT_REG_LO;
      ardm_filter u_filter (
        .code   (result_control_register[RI].reduction_control_field),
        .x0     (conv.data),
        .x1     (hist1[f]),
        .x2     (hist2[f]),
        .y_prev (conversion_result_register[RI]),
        .y      (filt_y[f])
      );

      // History holds the two previous raw results; writing a one to its bit of the init register zeroes it
      always_ff @(posedge ref_clk) begin
        if (reset || hist_init[f]) begin
          hist1[f] <= '0;
          hist2[f] <= '0;
        end else if (conv_valid && conv.idx == 4'(RI)) begin
          hist1[f] <= conv.data;
          hist2[f] <= hist1[f];
        end
      end
    end
  endgenerate

  assign hist_init = (wr && addr == FLT_INIT_OFS) ? wdata[1:0] : 2'b00;

  genvar r;
  generate
    for (r = 0; r < NUM_REGS; r++) begin : g_reg
      localparam int unsigned FI = (r == FILT_REG_HI) ? 1 : 0;
      wire logic hit    = conv_valid && conv.idx == 4'(r);
      wire ardm_ctrl_t cr = result_control_register[r];
      wire logic filt   = cr.modification_mode_field == MODE_FILTER && filt_slot(4'(r));
      wire logic fresh  = remaining_accumulation_counter[r] == 4'h0;

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          result_control_register[r] <= CTRL_RESET;
        end else if (wr_ctrl && addr[5:2] == 4'(r)) begin
          result_control_register[r] <= wdata[MODE_LSB+1:RED_LSB];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          conversion_result_register[r]     <= '0;
          remaining_accumulation_counter[r] <= 4'h0;
        end else if (reset == 1'b0 && filt && hist_init[FI]) begin
          conversion_result_register[r]     <= '0;
        end else if (hit && filt) begin
          conversion_result_register[r]     <= filt_y[FI];
        end else if (hit) begin
          if (fresh) begin
            // New sequence starts from the bare result; counter loads the code
            conversion_result_register[r]     <= RES_W'(conv.data);
            remaining_accumulation_counter[r] <= cr.reduction_control_field;
          end else begin
            // 16 x 4095 fits in 16 bits, so the raw sum never wraps
            conversion_result_register[r]     <= conversion_result_register[r] + RES_W'(conv.data);
            remaining_accumulation_counter[r] <= remaining_accumulation_counter[r] - 4'h1;
          end
        end
      end

      // Event on every filtered result; when reducing, only once the counter is at zero after this result
      assign event_set[r] = hit && (filt || (fresh ? cr.reduction_control_field == RED_NONE
                                                   : remaining_accumulation_counter[r] == 4'h1));
      assign rd_clear[r]  = rd_res && addr[5:2] == 4'(r);

      // Valid set wins over a same-cycle read clear
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          result_valid_flag[r] <= 1'b0;
        end else if (event_set[r]) begin
          result_valid_flag[r] <= 1'b1;
        end else if (rd_clear[r] || (hit && fresh)) begin
          result_valid_flag[r] <= 1'b0;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          status[r] <= 1'b0;
        end else if (event_set[r]) begin
          status[r] <= 1'b1;
        end else if (wr && addr == STATUS_OFS && wdata[r]) begin
          status[r] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask <= '0;
    end else if (wr && addr == MASK_OFS) begin
      mask <= wdata[NUM_REGS-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // Read data one cycle after the strobe, zero otherwise; unmapped reads return zero
  always_ff @(posedge ref_clk) begin
    if (reset || !rd) begin
      rdata <= '0;
    end else if (addr[7:6] == CTRL_BASE[7:6]) begin
      rdata <= DATA_W'(result_control_register[wr_idx]);
    end else if (addr[7:6] == RES_BASE[7:6]) begin
      rdata <= DATA_W'({result_valid_flag[wr_idx], remaining_accumulation_counter[wr_idx],
                        conversion_result_register[wr_idx]});
    end else if (addr == STATUS_OFS) begin
      rdata <= DATA_W'(status);
    end else if (addr == MASK_OFS) begin
      rdata <= DATA_W'(mask);
    end else begin
      rdata <= '0;
    end
  end

  // Fixed register picks keep each check cheap; the bench steers results to these registers
  a_irq_follows: assert property (
    @(posedge ref_clk) disable iff (reset)
    |(status & mask)
    |=> irq)
    else $error("irq not raised");

  a_irq_low: assert property (
    @(posedge ref_clk) disable iff (reset)
    !(|(status & mask))
    |=> !irq)
    else $error("irq raised without cause");

  a_reduce_last: assert property (
    @(posedge ref_clk) disable iff (reset)
    event_set[0] && result_control_register[0].modification_mode_field == MODE_REDUCE
    |=> result_valid_flag[0] && remaining_accumulation_counter[0] == 4'h0)
    else $error("reduction event before count done");

  a_no_early_event: assert property (
    @(posedge ref_clk) disable iff (reset)
    remaining_accumulation_counter[0] > 4'h1
    |-> !event_set[0])
    else $error("event before count exhausted");

  a_valid_set: assert property (
    @(posedge ref_clk) disable iff (reset)
    event_set[3]
    |=> result_valid_flag[3])
    else $error("valid not set");

  a_valid_read_clr: assert property (
    @(posedge ref_clk) disable iff (reset)
    rd_clear[3] && !event_set[3]
    |=> !result_valid_flag[3])
    else $error("valid not cleared by read");

  a_valid_new_seq: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'h0 && remaining_accumulation_counter[0] == 4'h0
    && result_control_register[0].reduction_control_field != RED_NONE
    |=> !result_valid_flag[0])
    else $error("valid kept at sequence start");

  a_status_clear: assert property (
    @(posedge ref_clk) disable iff (reset)
    wr && addr == STATUS_OFS && wdata[3] && !event_set[3]
    |=> !status[3])
    else $error("status not cleared");

  a_status_sticky: assert property (
    @(posedge ref_clk) disable iff (reset)
    status[3] && !(wr && addr == STATUS_OFS)
    |=> status[3])
    else $error("status lost");

  a_filt_slot_only: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'h3 && result_control_register[3].modification_mode_field == MODE_FILTER
    && remaining_accumulation_counter[3] == 4'h0
    |=> conversion_result_register[3] == RES_W'($past(conv.data)))
    else $error("filter on plain reg");

  a_direct_store: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'h2 && result_control_register[2] == CTRL_RESET
    |=> conversion_result_register[2] == RES_W'($past(conv.data)) && status[2])
    else $error("direct store wrong");

  a_count_load: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'h0 && result_control_register[0] == 6'h0f
    && remaining_accumulation_counter[0] == 4'h0
    |=> remaining_accumulation_counter[0] == 4'hf)
    else $error("sixteen count not loaded");

  a_count_dec: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'h0 && remaining_accumulation_counter[0] != 4'h0
    |=> remaining_accumulation_counter[0] == $past(remaining_accumulation_counter[0]) - 4'h1)
    else $error("count not decremented");

  a_sum_add: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'h0 && remaining_accumulation_counter[0] != 4'h0
    |=> conversion_result_register[0] == $past(conversion_result_register[0]) + RES_W'($past(conv.data)))
    else $error("raw sum wrong");

  a_ctrl_write: assert property (
    @(posedge ref_clk) disable iff (reset)
    wr && addr == 8'h1c
    |=> result_control_register[7] == $past(wdata[5:0]))
    else $error("control write lost");

  a_fir_result: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'h7 && result_control_register[7] == 6'h13
    |=> conversion_result_register[7] == RES_W'($past(conv.data)) + RES_W'($past(hist1[0]))
        + RES_W'($past(hist2[0])))
    else $error("fir 1,1,1 wrong");

  a_fir_gain3: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'hf && result_control_register[15] == 6'h10 && !hist_init[1]
    |=> conversion_result_register[15] == (RES_W'($past(conv.data)) << 1) + RES_W'($past(hist1[1])))
    else $error("fir 2,1,0 wrong");

  a_fir_gain4: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'hf && result_control_register[15] == 6'h16 && !hist_init[1]
    |=> conversion_result_register[15] == (RES_W'($past(conv.data)) << 1) + (RES_W'($past(hist1[1])) << 1))
    else $error("fir 2,2,0 wrong");

  a_iir_a2b2: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'h7 && result_control_register[7] == 6'h1e && !hist_init[0]
    |=> conversion_result_register[7] == ($past(conversion_result_register[7]) >> 1) + (RES_W'($past(conv.data)) << 1))
    else $error("iir 2,2 wrong");

  a_iir_a3b4: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'hf && result_control_register[15] == 6'h1f && !hist_init[1]
    |=> conversion_result_register[15] == RES_W'((18'($past(conversion_result_register[15])) * 18'd3) >> 2)
        + RES_W'($past(conv.data)))
    else $error("iir 3,4 wrong");

  a_filt_14bit: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'h7 && result_control_register[7].modification_mode_field == MODE_FILTER
    && conversion_result_register[7][15:14] == 2'b00 && !hist_init[0]
    |=> conversion_result_register[7][15:14] == 2'b00)
    else $error("filtered value above 14 bits");

  a_hist_shift: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_valid && conv.idx == 4'h7 && !hist_init[0]
    |=> hist1[0] == $past(conv.data) && hist2[0] == $past(hist1[0]))
    else $error("history not shifted");

  a_hist_init: assert property (
    @(posedge ref_clk) disable iff (reset)
    hist_init[1]
    |=> hist1[1] == '0 && hist2[1] == '0)
    else $error("history not cleared");

  a_res_init: assert property (
    @(posedge ref_clk) disable iff (reset)
    hist_init[0] && result_control_register[7].modification_mode_field == MODE_FILTER
    |=> conversion_result_register[7] == '0)
    else $error("filtered result not cleared");

  a_rdata_idle: assert property (
    @(posedge ref_clk) disable iff (reset)
    !rd
    |=> rdata == '0)
    else $error("read data without strobe");

  // Main scenarios
  c_irq: cover property (@(posedge ref_clk) irq);
  c_sum_done: cover property (@(posedge ref_clk) event_set[0] && remaining_accumulation_counter[0] == 4'h1);
  c_filter: cover property (@(posedge ref_clk) event_set[15] && result_control_register[15] == 6'h1f);
  c_iir_low: cover property (@(posedge ref_clk) event_set[7] && result_control_register[7] == 6'h1e);
  c_restart: cover property (@(posedge ref_clk) conv_valid && conv.idx == 4'h0 && result_control_register[0] == 6'h0f);
endmodule

// >>> test/ardm_conv_src.sv
/*
 Behavioural converter core that hands conversion results to the modification stage.
 Assumes the bench calls send() from one process and ref_clk is free running.
*/
`timescale 1ns/100ps
module ardm_conv_src
  import ardm_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  reset,
  output logic       conv_valid,
  output ardm_conv_t conv
);
  initial begin
    conv_valid = 1'b0;
    conv       = '0;
  end

  // Gap idles the core for a few cycles before the strobe; even at gap 0 one idle cycle separates results
  task automatic send(input logic [IDX_W-1:0] idx, input logic [CONV_W-1:0] data, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk iff !reset);
    conv_valid <= 1'b1;
    conv       <= '{idx: idx, data: data};
    @(posedge ref_clk);
    conv_valid <= 1'b0;
    // Lines are not held past the strobe, so a stale sample shows up as wrong data
    conv       <= '{idx: ~idx, data: ~data};
  endtask
endmodule

// >>> test/adc_result_data_modification_test.sv
/*
 Self-checking bench for the result modification stage: accumulation, FIR/IIR filtering, interrupt.
 Assumes the converter model in ardm_conv_src and the register map of ardm_pkg.
*/
`timescale 1ns/100ps
module adc_result_data_modification_test
  import ardm_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              reset   = 1'b1;
  logic              wr      = 1'b0;
  logic              rd      = 1'b0;
  logic              conv_valid;
  logic              irq;
  logic              msk;
  ardm_conv_t        conv;
  logic [ADDR_W-1:0] addr    = '0;
  logic [DATA_W-1:0] wdata   = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] r;
  logic [IDX_W-1:0]  idx;
  logic [3:0]        code;
  logic [1:0]        mode;
  logic [15:0]       sum;
  logic [15:0]       y;
  logic [11:0]       d;
  logic [11:0]       x1;
  logic [11:0]       x2;
  int                fail_count  = 0;
  int                comparisons = 0;
  integer            seed        = 32'h2d861373;
  ardm_coef_t        fir_tab [14] = '{6'h24, 6'h18, 6'h21, 6'h15, 6'h12, 6'h34, 6'h28,
                                       6'h1c, 6'h31, 6'h25, 6'h19, 6'h22, 6'h16, 6'h13};

  always #4 ref_clk = ~ref_clk;

  ardm_top i_dut (.ref_clk(ref_clk), .reset(reset), .conv_valid(conv_valid), .conv(conv), .addr(addr),
                  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  ardm_conv_src i_src (.ref_clk(ref_clk), .reset(reset), .conv_valid(conv_valid), .conv(conv));

  function automatic logic [15:0] filt_exp(input logic [3:0] c, input logic [11:0] a0, input logic [11:0] a1,
                                           input logic [11:0] a2, input logic [15:0] yp);
    ardm_coef_t k;
    if (c == IIR_A2B2) return (yp * 16'h2) / 16'h4 + 16'h2 * 16'(a0);
    if (c == IIR_A3B4) return (yp * 16'h3) / 16'h4 + 16'(a0);
    k = fir_tab[c];
    return 16'(k.a) * 16'(a0) + 16'(k.b) * 16'(a1) + 16'(k.c) * 16'(a2);
  endfunction

  function automatic logic [ADDR_W-1:0] reg_at(input logic [ADDR_W-1:0] base, input logic [IDX_W-1:0] n);
    return base + ADDR_W'({n, 2'b00});
  endfunction

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge ref_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  // Result lands one cycle after the strobe, irq one more; the reader waits for both
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rd_reg(CTRL_BASE, r);
    check(r, 32'(CTRL_RESET));
    wr_reg(RES_BASE, '1);
    rd_reg(RES_BASE, r);
    check(r, '0);
    wr_reg(8'hfc, 32'h5a5a5a5a);
    rd_reg(8'hfc, r);
    check(r, '0);
    // Accumulation: empty, shortest, longest at full scale, then random codes and modes
    for (int t = 0; t < 8; t++) begin
      // Corner picks: direct store on 2, filter mode on a plain register 3, sixteen on 0
      idx  = (t == 0) ? 4'h2 : (t == 1) ? 4'h3 : (t == 2) ? 4'h0 : IDX_W'($random(seed));
      code = (t == 0) ? RED_NONE : (t == 1) ? 4'h1 : (t == 2) ? 4'hf : 4'($random(seed));
      mode = (t == 1) ? MODE_FILTER :
             (t < 3 || idx == IDX_W'(FILT_REG_LO) || idx == IDX_W'(FILT_REG_HI)) ? MODE_REDUCE : 2'($random(seed));
      msk  = 1'($random(seed));
      wr_reg(reg_at(CTRL_BASE, idx), 32'({mode, code}));
      rd_reg(reg_at(CTRL_BASE, idx), r);
      check(r, 32'({mode, code}));
      wr_reg(MASK_OFS, 32'(msk) << idx);
      sum = '0;
      for (int i = 0; i <= int'(code); i++) begin
        d = (t == 2) ? 12'hfff : 12'($random(seed));
        sum += 16'(d);
        i_src.send(idx, d, $random(seed) & 3);
        settle();
        check(32'(irq), 32'(msk && i == int'(code)));
      end
      rd_reg(reg_at(RES_BASE, idx), r);
      check(r, {11'h0, 1'b1, 4'h0, sum});
      rd_reg(reg_at(RES_BASE, idx), r);
      check(32'(r[VALID_BIT]), 32'h0);
      wr_reg(STATUS_OFS, 32'h1 << idx);
      settle();
      check(32'(irq), 32'h0);
    end
    // Every filter code on both filtering registers, events masked throughout
    wr_reg(MASK_OFS, '0);
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 16; c++) begin
        idx  = f ? IDX_W'(FILT_REG_HI) : IDX_W'(FILT_REG_LO);
        code = 4'(c);
        wr_reg(reg_at(CTRL_BASE, idx), 32'({MODE_FILTER, code}));
        wr_reg(FLT_INIT_OFS, 32'(f + 1));
        rd_reg(reg_at(RES_BASE, idx), r);
        check(32'(r[15:0]), 32'h0);
        x1 = '0;
        x2 = '0;
        y  = '0;
        for (int n = 0; n < 4; n++) begin
          d = (n == 1) ? 12'hfff : 12'($random(seed));
          i_src.send(idx, d, n);
          settle();
          y  = filt_exp(code, d, x1, x2, y);
          x2 = x1;
          x1 = d;
          rd_reg(reg_at(RES_BASE, idx), r);
          check(32'(r[15:0]), 32'(y));
          check(32'({r[15:14], irq}), 32'h0);
        end
      end
    end
    // Sticky filter events show once unmasked and go with a write-one clear
    wr_reg(MASK_OFS, 32'h8080);
    settle();
    check(32'(irq), 32'h1);
    wr_reg(STATUS_OFS, 32'hffff);
    settle();
    check(32'(irq), 32'h0);
    give_verdict();
  end
endmodule
